// ===== hdl/rcr_regs.sv
// regulator control register bank behind a serial slave port
// Functional notes
// - supply undervoltage returns every register to its default value.
// - respond at 7-bit address; byte 0x30 writes, 0x31 reads.
// - identity is read-only: variant in 6:3, revision in 2:0, bit 7 zero.
// - status bits 3:0: over-temperature, power-good, overvoltage, overcurrent.
// - ramp config bit 5 picks rising ramp 12.5 or 25 mV/us.
// - ramp config bit 4 picks falling ramp 3.125 or 6.25 mV/us.
// - bits 3:2 pick overvoltage limit: off, 110, 115, 120 percent.
// - ramp config bit 1 enables active output discharge.
// - ramp config bit 0 selects skip mode or forced PWM.
// - ramp config resets to 0x0e.
// - output config bit 6 enables the output; register resets to 0x70.
// - output config bit 5 connects the enable pin pulldown.
// - output config bit 4 sets power-good pin polarity, 1 active high.
// - select pin low uses the low-select voltage register at 0x04.
// - select pin high uses the high-select voltage register at 0x05.
// - voltage code maps to 2.6 V plus 12.5 mV per step.
// - low-select resets to 0x38, high-select to 0x40; bit 7 reserved.
// - every stop clears the register pointer to 0x00.
// - write carries pointer then data; data applies after its ack clock.
`timescale 1ns/100ps
`default_nettype none
module rcr_regs
	import rcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic system_supply_low,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic over_temperature_flag,
	input wire logic output_good_flag,
	input wire logic overvoltage_flag,
	input wire logic overcurrent_flag,
	input wire logic voltage_select_pin,
	output logic rise_slew_select,
	output logic fall_slew_select,
	output logic [1:0] overvoltage_threshold,
	output logic active_discharge_enable,
	output logic forced_pwm_select,
	output logic output_enable_bit,
	output logic enable_pin_pulldown,
	output logic power_good_polarity,
	output logic power_good_pin,
	output logic [6:0] target_voltage_code,
	output logic [15:0] target_voltage_tmv,
	output logic [15:0] rise_rate_uv_us,
	output logic [15:0] fall_rate_uv_us,
	output logic [7:0] ovp_limit_pct
);

	// read value of a register offset
	function automatic logic [7:0] read_byte(
		input logic [7:0] ofs,
		input logic [7:0] ramp_cfg,
		input logic [7:0] out_cfg,
		input logic [7:0] vlow,
		input logic [7:0] vhigh,
		input logic [3:0] stat);
		logic [7:0] v;
		v = 8'h00;
		unique case (ofs)
			OFS_IDENTITY: v = {1'b0, VARIANT_CODE, REVISION_CODE};
			OFS_STATUS: v = {4'h0, stat};
			OFS_RAMP_CFG: v = ramp_cfg & RAMP_CFG_WMASK;
			OFS_OUT_CFG: v = out_cfg & OUT_CFG_WMASK;
			OFS_VLOW: v = vlow & VOUT_WMASK;
			OFS_VHIGH: v = vhigh & VOUT_WMASK;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	logic rst_all, scl_rise, scl_fall, start_seen, stop_seen, sda_bit;
	rcr_state_e state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt, status_now;
	logic [7:0] shift_r, shift_nxt, ptr_r, ptr_nxt, rd_now;
	logic sda_oe_r, sda_oe_nxt, sda_out_r, pg_pin_r;
	logic [7:0] ramp_cfg_r, out_cfg_r, vlow_r, vhigh_r, ovp_pct_r, ovp_sel;
	logic [7:0] wr_ramp, wr_out, wr_vout;
	logic [6:0] code_r, code_sel;
	logic [15:0] tmv_r, rise_rate_r, fall_rate_r;
	logic [15:0] tmv_sel, rise_sel, fall_sel;
	logic byte_done, addr_match, commit_wr;

	// undervoltage of the system supply resets the whole bank
	assign rst_all = sys_rst | system_supply_low;
	rcr_line_watch u_watch
	(
		.sys_clk(sys_clk),
		.sys_rst(rst_all),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_seen(start_seen),
		.stop_seen(stop_seen),
		.sda_bit(sda_bit)
	);
	assign status_now = {over_temperature_flag, output_good_flag,
		overvoltage_flag, overcurrent_flag};
	assign rd_now = read_byte(ptr_r, ramp_cfg_r, out_cfg_r, vlow_r, vhigh_r,
		status_now);
	assign byte_done = scl_fall & (cnt_r == BYTE_BITS);
	assign addr_match = (shift_r[7:1] == SLAVE_ADDR);
	// data lands on the falling clock that ends its acknowledge
	assign commit_wr = (state_r == ST_WDATA_ACK) & scl_fall &
		~start_seen & ~stop_seen;
	// reserved bits of written data are dropped
	assign wr_ramp = shift_r & RAMP_CFG_WMASK;
	assign wr_out = shift_r & OUT_CFG_WMASK;
	assign wr_vout = shift_r & VOUT_WMASK;
	// bus transaction sequencing
	always_comb
	begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		ptr_nxt = ptr_r;
		sda_oe_nxt = sda_oe_r;
		if (stop_seen)
		begin
			state_nxt = ST_IDLE;
			ptr_nxt = PTR_RESET;
			sda_oe_nxt = 1'b0;
			cnt_nxt = 4'h0;
		end
		else if (start_seen)
		begin
			state_nxt = ST_ADDR;
			sda_oe_nxt = 1'b0;
			cnt_nxt = 4'h0;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE: cnt_nxt = 4'h0;
				ST_ADDR, ST_PTR, ST_WDATA:
				begin
					if (scl_rise)
					begin
						shift_nxt = {shift_r[6:0], sda_bit};
						cnt_nxt = cnt_r + 4'h1;
					end
					else if (byte_done)
					begin
						cnt_nxt = 4'h0;
						sda_oe_nxt = 1'b1;
						if (state_r == ST_ADDR)
						begin
							// other addresses, master codes included, get no ack
							if (addr_match)
								state_nxt = ST_ADDR_ACK;
							else
							begin
								state_nxt = ST_IDLE;
								sda_oe_nxt = 1'b0;
							end
						end
						else if (state_r == ST_PTR)
							state_nxt = ST_PTR_ACK;
						else
							state_nxt = ST_WDATA_ACK;
					end
				end
				ST_ADDR_ACK:
				begin
					if (scl_fall)
					begin
						if (shift_r[0])
						begin
							// read: load addressed byte, drive its top bit
							state_nxt = ST_RDATA;
							shift_nxt = rd_now;
							ptr_nxt = ptr_r + 8'h01;
							sda_oe_nxt = ~rd_now[7];
						end
						else
						begin
							state_nxt = ST_PTR;
							sda_oe_nxt = 1'b0;
						end
					end
				end
				ST_PTR_ACK, ST_WDATA_ACK:
				begin
					if (scl_fall)
					begin
						ptr_nxt = (state_r == ST_PTR_ACK) ? shift_r :
							ptr_r + 8'h01;
						state_nxt = ST_WDATA;
						sda_oe_nxt = 1'b0;
					end
				end
				ST_RDATA:
				begin
					if (scl_rise)
						cnt_nxt = cnt_r + 4'h1;
					else if (byte_done)
					begin
						cnt_nxt = 4'h0;
						sda_oe_nxt = 1'b0;
						state_nxt = ST_RDATA_ACK;
					end
					else if (scl_fall)
					begin
						shift_nxt = {shift_r[6:0], 1'b0};
						sda_oe_nxt = ~shift_r[6];
					end
				end
				ST_RDATA_ACK:
				begin
					// master ack is sampled on the rising clock
					if (scl_rise)
						cnt_nxt = {3'h0, sda_bit};
					else if (scl_fall)
					begin
						cnt_nxt = 4'h0;
						if (cnt_r == 4'h0)
						begin
							state_nxt = ST_RDATA;
							shift_nxt = rd_now;
							ptr_nxt = ptr_r + 8'h01;
							sda_oe_nxt = ~rd_now[7];
						end
						else
							state_nxt = ST_IDLE;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst_all)
		begin
			state_r <= ST_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ptr_r <= PTR_RESET;
			sda_oe_r <= 1'b0;
			sda_out_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			ptr_r <= ptr_nxt;
			sda_oe_r <= sda_oe_nxt;
			sda_out_r <= 1'b0;
		end
	end

	// register file; unmapped offsets swallow the data
	always_ff @(posedge sys_clk)
	begin
		if (rst_all)
		begin
			ramp_cfg_r <= RAMP_CFG_RST;
			out_cfg_r <= OUT_CFG_RST;
			vlow_r <= VLOW_RST;
			vhigh_r <= VHIGH_RST;
		end
		else if (commit_wr)
		begin
			if (ptr_r == OFS_RAMP_CFG)
				ramp_cfg_r <= wr_ramp;
			if (ptr_r == OFS_OUT_CFG)
				out_cfg_r <= wr_out;
			if (ptr_r == OFS_VLOW)
				vlow_r <= wr_vout;
			if (ptr_r == OFS_VHIGH)
				vhigh_r <= wr_vout;
		end
	end
	// regulator set points derived from the registers
	assign code_sel = voltage_select_pin ? vhigh_r[6:0] :
		vlow_r[6:0];
	assign tmv_sel = VOUT_BASE_TMV +
		16'(VOUT_STEP_TMV * {9'h000, code_sel});
	assign rise_sel = ramp_cfg_r[RISE_SLEW_BIT] ? RISE_FAST_UV_US :
		RISE_SLOW_UV_US;
	assign fall_sel = ramp_cfg_r[FALL_SLEW_BIT] ? FALL_FAST_UV_US :
		FALL_SLOW_UV_US;
	assign ovp_sel = (ramp_cfg_r[OVP_TH_HI:OVP_TH_LO] == 2'b00) ? OVP_PCT_OFF :
		(ramp_cfg_r[OVP_TH_HI:OVP_TH_LO] == 2'b01) ? OVP_PCT_110 :
		(ramp_cfg_r[OVP_TH_HI:OVP_TH_LO] == 2'b10) ? OVP_PCT_115 :
		OVP_PCT_120;
	always_ff @(posedge sys_clk)
	begin
		if (rst_all)
		begin
			code_r <= 7'h00;
			tmv_r <= 16'h0000;
			rise_rate_r <= 16'h0000;
			fall_rate_r <= 16'h0000;
			ovp_pct_r <= 8'h00;
			pg_pin_r <= 1'b0;
		end
		else
		begin
			code_r <= code_sel;
			tmv_r <= tmv_sel;
			rise_rate_r <= rise_sel;
			fall_rate_r <= fall_sel;
			ovp_pct_r <= ovp_sel;
			// active low pin shows good as a low level
			pg_pin_r <= output_good_flag ~^ out_cfg_r[PG_POL_BIT];
		end
	end

	assign sda_out = sda_out_r;
	assign sda_oe = sda_oe_r;
	assign rise_slew_select = ramp_cfg_r[RISE_SLEW_BIT];
	assign fall_slew_select = ramp_cfg_r[FALL_SLEW_BIT];
	assign overvoltage_threshold = ramp_cfg_r[OVP_TH_HI:OVP_TH_LO];
	assign active_discharge_enable = ramp_cfg_r[DISCHARGE_BIT];
	assign forced_pwm_select = ramp_cfg_r[FPWM_BIT];
	assign output_enable_bit = out_cfg_r[OUT_EN_BIT];
	assign enable_pin_pulldown = out_cfg_r[ENABLE_PIN_PULLDOWN_BIT];
	assign power_good_polarity = out_cfg_r[PG_POL_BIT];
	assign power_good_pin = pg_pin_r;
	assign target_voltage_code = code_r;
	assign target_voltage_tmv = tmv_r;
	assign rise_rate_uv_us = rise_rate_r;
	assign fall_rate_uv_us = fall_rate_r;
	assign ovp_limit_pct = ovp_pct_r;

endmodule
`default_nettype wire

// ===== hdl/rcr_pkg.sv
// constants of the regulator control register bank
package rcr_pkg;

	// serial slave address: 0x30 write byte, 0x31 read byte
	localparam logic [6:0] SLAVE_ADDR = 7'h18;
	localparam logic [7:0] ADDR_WR_BYTE = 8'h30;
	localparam logic [7:0] ADDR_RD_BYTE = 8'h31;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// register offsets
	localparam logic [7:0] OFS_IDENTITY = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h01;
	localparam logic [7:0] OFS_RAMP_CFG = 8'h02;
	localparam logic [7:0] OFS_OUT_CFG = 8'h03;
	localparam logic [7:0] OFS_VLOW = 8'h04;
	localparam logic [7:0] OFS_VHIGH = 8'h05;
	localparam logic [7:0] PTR_RESET = 8'h00;

	// values after reset
	localparam logic [7:0] RAMP_CFG_RST = 8'h0e;
	localparam logic [7:0] OUT_CFG_RST = 8'h70;
	localparam logic [7:0] VLOW_RST = 8'h38;
	localparam logic [7:0] VHIGH_RST = 8'h40;

	// writable bits; all others are reserved and read zero
	localparam logic [7:0] RAMP_CFG_WMASK = 8'h3f;
	localparam logic [7:0] OUT_CFG_WMASK = 8'h70;
	localparam logic [7:0] VOUT_WMASK = 8'h7f;

	// field positions
	localparam int RISE_SLEW_BIT = 5;
	localparam int FALL_SLEW_BIT = 4;
	localparam int OVP_TH_HI = 3;
	localparam int OVP_TH_LO = 2;
	localparam int DISCHARGE_BIT = 1;
	localparam int FPWM_BIT = 0;
	localparam int OUT_EN_BIT = 6;
	localparam int ENABLE_PIN_PULLDOWN_BIT = 5;
	localparam int PG_POL_BIT = 4;
	localparam int ID_VARIANT_LO = 3;
	localparam int STAT_TEMP_BIT = 3;

	// identity fields; values are arbitrary
	localparam logic [3:0] VARIANT_CODE = 4'h5;
	localparam logic [2:0] REVISION_CODE = 3'h5;

	// ramp rates in uV/us, threshold in percent, target in 0.1 mV units
	localparam logic [15:0] RISE_SLOW_UV_US = 16'h30d4;
	localparam logic [15:0] RISE_FAST_UV_US = 16'h61a8;
	localparam logic [15:0] FALL_SLOW_UV_US = 16'h0c35;
	localparam logic [15:0] FALL_FAST_UV_US = 16'h186a;
	localparam logic [7:0] OVP_PCT_OFF = 8'h00;
	localparam logic [7:0] OVP_PCT_110 = 8'h6e;
	localparam logic [7:0] OVP_PCT_115 = 8'h73;
	localparam logic [7:0] OVP_PCT_120 = 8'h78;
	localparam logic [15:0] VOUT_BASE_TMV = 16'h6590;
	localparam logic [15:0] VOUT_STEP_TMV = 16'h007d;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0000,
		ST_ADDR = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_PTR = 4'b0011,
		ST_PTR_ACK = 4'b0100,
		ST_WDATA = 4'b0101,
		ST_WDATA_ACK = 4'b0110,
		ST_RDATA = 4'b0111,
		ST_RDATA_ACK = 4'b1000
	} rcr_state_e;

endpackage

// ===== hdl/rcr_line_watch.sv
// serial line edge, start and stop detection
`timescale 1ns/100ps
`default_nettype none
module rcr_line_watch
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_seen,
	output logic stop_seen,
	output logic sda_bit
);

	logic scl_q_r;
	logic sda_q_r;

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end
		else
		begin
			scl_q_r <= scl_in;
			sda_q_r <= sda_in;
		end
	end

	assign scl_rise = ~scl_q_r & scl_in;
	assign scl_fall = scl_q_r & ~scl_in;
	// data moving while the clock is high frames a transfer
	assign start_seen = scl_q_r & scl_in & sda_q_r & ~sda_in;
	assign stop_seen = scl_q_r & scl_in & ~sda_q_r & sda_in;
	assign sda_bit = sda_in;

endmodule
`default_nettype wire

// ===== bench/rcr_regs_assertions.sv
// bound checker for the regulator control register bank
`timescale 1ns/100ps
`default_nettype none
module rcr_regs_chk
	import rcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic system_supply_low,
	input wire logic scl_in,
	input wire logic sda_oe,
	input wire logic output_good_flag,
	input wire logic rise_slew_select,
	input wire logic fall_slew_select,
	input wire logic [1:0] overvoltage_threshold,
	input wire logic active_discharge_enable,
	input wire logic forced_pwm_select,
	input wire logic output_enable_bit,
	input wire logic enable_pin_pulldown,
	input wire logic power_good_polarity,
	input wire logic power_good_pin,
	input wire logic [6:0] target_voltage_code,
	input wire logic [15:0] target_voltage_tmv,
	input wire logic [15:0] rise_rate_uv_us,
	input wire logic [15:0] fall_rate_uv_us,
	input wire logic [7:0] ovp_limit_pct
);
	logic live_r;
	wire in_rst = sys_rst | system_supply_low;
	wire [5:0] ramp_f = {rise_slew_select, fall_slew_select,
		overvoltage_threshold, active_discharge_enable, forced_pwm_select};
	default clocking cb @(posedge sys_clk);
	endclocking
	// high once the previous cycle was out of reset
	always_ff @(posedge sys_clk)
		live_r <= !in_rst;
	function automatic logic [7:0] pct_of(input logic [1:0] t);
		return t == 2'h0 ? OVP_PCT_OFF : t == 2'h1 ? OVP_PCT_110 :
			t == 2'h2 ? OVP_PCT_115 : OVP_PCT_120;
	endfunction
	sequence code_held;
		$stable(target_voltage_code) ##1 $stable(target_voltage_code);
	endsequence
	a_supply_ramp_dflt: assert property (disable iff (sys_rst)
		system_supply_low |=> ramp_f == 6'h0e)
		else $error("ramp fields not at default after supply low");
	a_supply_out_dflt: assert property (disable iff (sys_rst)
		system_supply_low |=> output_enable_bit && enable_pin_pulldown &&
		power_good_polarity)
		else $error("output fields not at default after supply low");
	a_rise_rate_map: assert property (disable iff (in_rst)
		live_r |-> rise_rate_uv_us == ($past(rise_slew_select) ?
		RISE_FAST_UV_US : RISE_SLOW_UV_US))
		else $error("rise rate does not follow its select bit");
	a_fall_rate_map: assert property (disable iff (in_rst)
		live_r |-> fall_rate_uv_us == ($past(fall_slew_select) ?
		FALL_FAST_UV_US : FALL_SLOW_UV_US))
		else $error("fall rate does not follow its select bit");
	a_ovp_pct_map: assert property (disable iff (in_rst)
		live_r |-> ovp_limit_pct == pct_of($past(overvoltage_threshold)))
		else $error("overvoltage limit does not follow threshold field");
	a_target_tmv_map: assert property (disable iff (in_rst)
		live_r ##0 code_held |-> target_voltage_tmv ==
		VOUT_BASE_TMV + VOUT_STEP_TMV * {9'h000, target_voltage_code})
		else $error("target voltage does not match its code");
	a_pg_polarity: assert property (disable iff (in_rst)
		live_r |-> power_good_pin ==
		($past(output_good_flag) ~^ $past(power_good_polarity)))
		else $error("power good pin polarity wrong");
	a_sda_scl_low: assert property (disable iff (in_rst)
		$changed(sda_oe) |-> !$past(scl_in))
		else $error("data line changed while serial clock high");
	a_cfg_on_fall: assert property (disable iff (in_rst)
		live_r && !$stable(ramp_f) |-> !$past(scl_in) && $past(scl_in, 2))
		else $error("config changed outside the ack clock fall");
endmodule
bind rcr_regs rcr_regs_chk chk_u (.sys_clk, .sys_rst, .system_supply_low,
	.scl_in, .sda_oe, .output_good_flag, .rise_slew_select,
	.fall_slew_select, .overvoltage_threshold, .active_discharge_enable,
	.forced_pwm_select, .output_enable_bit, .enable_pin_pulldown,
	.power_good_polarity, .power_good_pin, .target_voltage_code,
	.target_voltage_tmv, .rise_rate_uv_us, .fall_rate_uv_us,
	.ovp_limit_pct);
`default_nettype wire

// ===== bench/rcr_host_model.sv
// serial bus master standing in for the host processor
`timescale 1ns/100ps
`default_nettype none
module rcr_host_model
	import rcr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_low
);
	// clocks per quarter bit; raised by the bench for slow traffic
	int ph = 4;
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// data moves only in the middle of the clock low phase
	task automatic clk_bit(input logic b, output logic s);
		tick(ph);
		sda_low <= ~b;
		tick(ph);
		scl <= 1'b1;
		tick(ph);
		#1 s = sda;
		tick(ph);
		scl <= 1'b0;
	endtask
	task automatic start;
		tick(ph);
		sda_low <= 1'b0;
		tick(ph);
		scl <= 1'b1;
		tick(ph);
		sda_low <= 1'b1;
		tick(ph);
		scl <= 1'b0;
	endtask
	task automatic stop;
		tick(ph);
		sda_low <= 1'b1;
		tick(ph);
		scl <= 1'b1;
		tick(ph);
		sda_low <= 1'b0;
		tick(ph);
	endtask
	task automatic tx(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask
	task automatic rx(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(last, s);
	endtask
	task automatic wr(input logic [7:0] adr, ptr, dat, output logic ok);
		logic a0, a1, a2;
		start;
		tx(adr, a0);
		tx(ptr, a1);
		tx(dat, a2);
		stop;
		ok = a0 & a1 & a2;
	endtask
	// two sequential bytes; the pointer phase is optional
	task automatic rd(input logic [7:0] ptr, input logic setp,
		output logic [7:0] d0, d1);
		logic a;
		if (setp)
		begin
			start;
			tx(ADDR_WR_BYTE, a);
			tx(ptr, a);
		end
		start;
		tx(ADDR_RD_BYTE, a);
		rx(1'b0, d0);
		rx(1'b1, d1);
		stop;
	endtask
endmodule
`default_nettype wire

// ===== bench/rcr_regs_tb_top.sv
// self-checking bench for the regulator control register bank
`timescale 1ns/100ps
`default_nettype none
module rcr_regs_tb_top
();
	logic sys_clk, sys_rst, system_supply_low, scl_in, sda_out, sda_oe;
	logic over_temperature_flag, output_good_flag, overvoltage_flag;
	logic overcurrent_flag, voltage_select_pin, mst_low, ok;
	logic rise_slew_select, fall_slew_select, active_discharge_enable;
	logic forced_pwm_select, output_enable_bit, enable_pin_pulldown;
	logic power_good_polarity, power_good_pin;
	logic [1:0] overvoltage_threshold;
	logic [6:0] target_voltage_code;
	logic [15:0] target_voltage_tmv, rise_rate_uv_us, fall_rate_uv_us;
	logic [7:0] ovp_limit_pct, d0, d1, v;
	logic [7:0] exp_t [0:6];
	logic [7:0] pct_t [0:3] = '{8'h00, 8'h6e, 8'h73, 8'h78};
	int n_mismatch = 0;
	int num_checks = 0;
	// open-drain wire with pull-up
	wire sda_in = !(mst_low || (sda_oe && !sda_out));
	wire [5:0] ramp_f = {rise_slew_select, fall_slew_select,
		overvoltage_threshold, active_discharge_enable, forced_pwm_select};
	wire [2:0] out_f = {output_enable_bit, enable_pin_pulldown,
		power_good_polarity};
	rcr_regs dut_u (.sys_clk, .sys_rst, .system_supply_low, .scl_in,
		.sda_in, .sda_out, .sda_oe, .over_temperature_flag,
		.output_good_flag, .overvoltage_flag, .overcurrent_flag,
		.voltage_select_pin, .rise_slew_select, .fall_slew_select,
		.overvoltage_threshold, .active_discharge_enable,
		.forced_pwm_select, .output_enable_bit, .enable_pin_pulldown,
		.power_good_polarity, .power_good_pin, .target_voltage_code,
		.target_voltage_tmv, .rise_rate_uv_us, .fall_rate_uv_us,
		.ovp_limit_pct);
	rcr_host_model mst_u (.sys_clk(sys_clk), .sda(sda_in), .scl(scl_in),
		.sda_low(mst_low));
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [15:0] got, exp);
		num_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic scan;
		for (int p = 0; p < 6; p++)
		begin
			mst_u.rd(8'(p), 1'b1, d0, d1);
			chk(d0, exp_t[p]);
			chk(d1, exp_t[p + 1]);
		end
	endtask
	initial
	begin
		repeat (100000) @(posedge sys_clk);
		n_mismatch++;
		report_and_stop;
	end
	initial
	begin
		sys_rst = 1'b1;
		system_supply_low = 1'b0;
		{over_temperature_flag, output_good_flag} = 2'h2;
		{overvoltage_flag, overcurrent_flag} = 2'h2;
		voltage_select_pin = 1'b0;
		exp_t = '{8'h2d, 8'h0a, 8'h0e, 8'h70, 8'h38, 8'h40, 8'h00};
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(ramp_f, 6'h0e);
		chk(out_f, 3'h7);
		chk(sda_out, 1'b0);
		scan;
		$display("defaults test done");
		for (int p = 0; p < 7; p++)
		begin
			mst_u.wr(8'h30, 8'(p), 8'hff, ok);
			chk(ok, 1'b1);
		end
		exp_t = '{8'h2d, 8'h0a, 8'h3f, 8'h70, 8'h7f, 8'h7f, 8'h00};
		scan;
		chk(target_voltage_code, 7'h7f);
		chk(target_voltage_tmv, 16'ha393);
		$display("write mask test done");
		for (int t = 0; t < 4; t++)
		begin
			mst_u.ph = 4 + 2 * t;
			v = {2'b00, t[1], t[0], t[1:0], t[0], t[1]};
			mst_u.wr(8'h30, 8'h02, v, ok);
			chk(ramp_f, v[5:0]);
			chk(ovp_limit_pct, pct_t[t]);
			chk(rise_rate_uv_us, t[1] ? 16'h61a8 : 16'h30d4);
			chk(fall_rate_uv_us, t[0] ? 16'h186a : 16'h0c35);
		end
		mst_u.ph = 4;
		$display("ramp config test done");
		mst_u.wr(8'h30, 8'h04, 8'h80, ok);
		mst_u.wr(8'h30, 8'h05, 8'h01, ok);
		chk(target_voltage_code, 7'h00);
		chk(target_voltage_tmv, 16'h6590);
		voltage_select_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		chk(target_voltage_code, 7'h01);
		chk(target_voltage_tmv, 16'h660d);
		$display("voltage select test done");
		for (int p = 0; p < 2; p++)
		begin
			mst_u.wr(8'h30, 8'h03, p ? 8'h1f : 8'h60, ok);
			chk(out_f, p ? 3'h1 : 3'h6);
			chk(power_good_pin, !p);
		end
		mst_u.wr(8'h32, 8'h02, 8'h00, ok);
		chk(ok, 1'b0);
		mst_u.wr(8'h08, 8'h02, 8'h00, ok);
		chk(ok, 1'b0);
		chk(ramp_f, 6'h3f);
		{over_temperature_flag, output_good_flag} <= 2'h1;
		{overvoltage_flag, overcurrent_flag} <= 2'h1;
		mst_u.rd(8'h03, 1'b1, d0, d1);
		chk({d0, d1}, 16'h1000);
		mst_u.rd(8'h00, 1'b0, d0, d1);
		chk({d0, d1}, 16'h2d05);
		chk(power_good_pin, 1'b1);
		$display("address and pointer test done");
		system_supply_low <= 1'b1;
		@(posedge sys_clk);
		system_supply_low <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(ramp_f, 6'h0e);
		chk(out_f, 3'h7);
		mst_u.rd(8'h04, 1'b1, d0, d1);
		chk({d0, d1}, 16'h3840);
		$display("supply reset test done");
		report_and_stop;
	end
endmodule
`default_nettype wire
